// [src/mvi_irq_ctrl.sv]
// Contract
// - Eighteen request sources merge onto ten fixed vector addresses.
// - Three levels, highest over high over low; equal or lower level is held off.
// - Among pending vectors, the highest level is granted.
// - Among equal levels, the smallest vector address is granted.
// - First external input uses 00003H, highest or low level only.
// - Second external input uses 0000BH, highest or low level only.
// - Third, fifth external inputs and timer zero low share 00013H, high or low.
// - Fourth external input and base timer share 0001BH, high or low.
// - Timer zero high uses 00023H; timer one low and high share 0002BH.
// - Sync serial unit and async port receive share 00033H, high or low.
// - Second serial unit and async port transmit share 0003BH, high or low.
// - Converter done, timer six and seven share 00043H, high or low.
// - Port zero pin interrupt uses 0004BH, high or low.
`default_nettype none
module mvi_irq_ctrl
  import mvi_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [MVI_NUM_SRC-1:0] src_in,
  input wire logic [MVI_NUM_VEC-1:0] vec_enable_in,
  input wire logic [MVI_NUM_VEC-1:0] vec_level_sel_in,
  input wire logic ack_in,
  input wire logic reti_in,
  output logic irq_req_out,
  output logic [MVI_VEC_W-1:0] vector_out,
  output logic [MVI_IDX_W-1:0] vector_index_out,
  output logic [1:0] req_level_out,
  output logic [1:0] service_level_out
);
  mvi_slot_if slot_if [MVI_NUM_VEC] ();

  // one merge slot per vector; source slices fixed by the vector table
  for (genvar i = 0; i < MVI_NUM_VEC; i++) begin : g_slot
    mvi_vec_slot #(
      .NSRC(MVI_VEC_COUNT[i]),
      .X_CAPABLE(MVI_VEC_X_CAPABLE[i])
    ) u_slot (
      .clk_in(clk_in),
      .reset_n_in(reset_n_in),
      .src_in(src_in[MVI_VEC_FIRST[i] +: MVI_VEC_COUNT[i]]),
      .enable_in(vec_enable_in[i]),
      .level_sel_in(vec_level_sel_in[i]),
      .slot_out(slot_if[i])
    );
  end

  logic [1:0] lvl_w [MVI_NUM_VEC];
  for (genvar i = 0; i < MVI_NUM_VEC; i++) begin : g_lvl
    assign lvl_w[i] = slot_if[i].pending ? slot_if[i].level : MVI_LVL_NONE;
  end

  // scan upward with strict compare so the lowest vector keeps a tie
  logic [1:0] best_lvl_w;
  logic [MVI_IDX_W-1:0] best_idx_w;
  always_comb begin
    best_lvl_w = MVI_LVL_NONE;
    best_idx_w = MVI_IDX_RESET;
    for (int i = 0; i < MVI_NUM_VEC; i++) begin
      if (lvl_w[i] > best_lvl_w) begin
        best_lvl_w = lvl_w[i];
        best_idx_w = MVI_IDX_W'(i);
      end
    end
  end

  // in-service levels as a small stack of one bit per level
  logic [2:0] in_svc_q;
  logic [2:0] in_svc_d;
  logic [1:0] svc_lvl_d;
  logic [1:0] cur_lvl_w;

  function automatic logic [1:0] mvi_top_level(input logic [2:0] m);
    logic [1:0] r;
    r = m[2] ? 2'h3 : (m[1] ? 2'h2 : (m[0] ? 2'h1 : 2'h0));
    return r;
  endfunction : mvi_top_level

  function automatic logic [2:0] mvi_level_bit(input logic [1:0] l);
    logic [2:0] r;
    r = (l == 2'h0) ? 3'h0 : (3'h1 << (l - 2'h1));
    return r;
  endfunction : mvi_level_bit

  assign cur_lvl_w = mvi_top_level(in_svc_q);
  wire logic take_w = irq_req_out & ack_in;
  // return pops the top level first, then an accepted request pushes its own
  wire logic [2:0] popped_w = reti_in ? (in_svc_q & ~mvi_level_bit(cur_lvl_w)) : in_svc_q;
  assign in_svc_d = take_w ? (popped_w | mvi_level_bit(req_level_out)) : popped_w;
  assign svc_lvl_d = mvi_top_level(in_svc_d);

  // request only above the level in service; dropped for one cycle after ack
  // so a stale vector is never offered twice
  wire logic accept_w = (best_lvl_w > cur_lvl_w) & ~take_w;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      in_svc_q <= MVI_SVC_RESET;
      service_level_out <= 2'h0;
    end else begin
      in_svc_q <= in_svc_d;
      service_level_out <= svc_lvl_d;
    end
  end

  // presented request, held registered for the core's vector fetch
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_req_out <= 1'b0;
      vector_out <= MVI_VEC_RESET;
      vector_index_out <= MVI_IDX_RESET;
      req_level_out <= 2'h0;
    end else begin
      irq_req_out <= accept_w;
      vector_out <= MVI_VEC_ADDR[best_idx_w];
      vector_index_out <= best_idx_w;
      req_level_out <= best_lvl_w;
    end
  end

  // helper terms that check the arbiter independently of its loop
  logic [MVI_NUM_VEC-1:0] beaten_w;
  for (genvar i = 0; i < MVI_NUM_VEC; i++) begin : g_chk
    assign beaten_w[i] = (lvl_w[i] > best_lvl_w) ||
      (lvl_w[i] == best_lvl_w && lvl_w[i] != 2'h0 && MVI_IDX_W'(i) < best_idx_w);
  end

  sequence s_taken;
    irq_req_out && ack_in;
  endsequence

  chk_req_above_service : assert property (@(posedge clk_in) disable iff (!reset_n_in)
    irq_req_out |-> req_level_out > service_level_out)
    else $error("request offered at or below service level");
  chk_arbiter_winner : assert property (@(posedge clk_in) disable iff (!reset_n_in)
    beaten_w == '0)
    else $error("a higher or lower-index equal vector was passed over");
  chk_lowest_tie : assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (lvl_w[0] != 2'h0 && lvl_w[0] == best_lvl_w) |-> best_idx_w == 4'h0)
    else $error("tie not given to smallest vector");
  chk_vector_address : assert property (@(posedge clk_in) disable iff (!reset_n_in)
    irq_req_out |-> vector_out == 16'h0003 + {8'h00, vector_index_out, 3'h0})
    else $error("vector address does not match index");
  chk_ack_raises_level : assert property (@(posedge clk_in) disable iff (!reset_n_in)
    s_taken |=> (service_level_out == $past(req_level_out)) && !irq_req_out)
    else $error("accepted request did not become service level");
  chk_reti_restore : assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (reti_in && !ack_in && in_svc_q == 3'h5) |=> service_level_out == 2'h1)
    else $error("return did not restore the earlier level");
  chk_highest_blocks : assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (service_level_out == 2'h3 && !reti_in) [*2] |-> !irq_req_out)
    else $error("request offered during highest level service");

  // offered vector kinds, so the level checks read plainly
  wire logic off_x_w = irq_req_out & (vector_index_out < MVI_IDX_W'(2));
  wire logic off_h_w = irq_req_out & (vector_index_out >= MVI_IDX_W'(2));

  // a return with no ack beside it, and a cycle with neither
  sequence s_return_alone;
    reti_in && !take_w;
  endsequence

  sequence s_quiet;
    !reti_in && !take_w;
  endsequence

  // the index drives a table lookup, so it must stay inside the table
  chk_index_in_range : assert property (@(posedge clk_in) disable iff (!reset_n_in)
    vector_index_out < MVI_IDX_W'(MVI_NUM_VEC))
    else $error("vector index outside the table");

  // the two external vectors never offer high, the rest never offer highest
  chk_ext_level_pair : assert property (@(posedge clk_in) disable iff (!reset_n_in)
    off_x_w |-> req_level_out != 2'h2)
    else $error("external vector offered at high level");
  chk_shared_level_pair : assert property (@(posedge clk_in) disable iff (!reset_n_in)
    off_h_w |-> req_level_out != 2'h3)
    else $error("shared vector offered at highest level");

  // nothing pending means nothing offered at the next edge
  chk_idle_no_req : assert property (@(posedge clk_in) disable iff (!reset_n_in)
    best_lvl_w == 2'h0 |=> !irq_req_out)
    else $error("request offered with nothing pending");

  // a return with no ack beside it and nothing in service must leave the level at none
  chk_reti_idle_noop : assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (s_return_alone and in_svc_q == 3'h0) |=> service_level_out == 2'h0)
    else $error("return with nothing in service changed the level");

  // the service stack moves only on an ack or a return
  chk_svc_stable : assert property (@(posedge clk_in) disable iff (!reset_n_in)
    s_quiet |=> $stable(in_svc_q))
    else $error("service stack moved without ack or return");

  // a return with no ack beside it always lowers the level while something is in service
  chk_reti_lowers : assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (s_return_alone and cur_lvl_w != 2'h0) |=> service_level_out < $past(cur_lvl_w))
    else $error("return did not lower the service level");

  // a disabled vector is never the one offered; checked vector by vector
  for (genvar i = 0; i < MVI_NUM_VEC; i++) begin : g_chk_en
    chk_disabled_ignored : assert property (@(posedge clk_in) disable iff (!reset_n_in)
      !vec_enable_in[i] |=> !(irq_req_out && vector_index_out == MVI_IDX_W'(i)))
      else $error("disabled vector was offered");
  end
endmodule : mvi_irq_ctrl
`default_nettype wire

// [shared/mvi_pkg.sv]
`default_nettype none
package mvi_pkg;
  // service and request levels, ordered so that a larger code wins
  typedef enum logic [1:0] {
    MVI_LVL_NONE    = 2'b00,
    MVI_LVL_LOW     = 2'b01,
    MVI_LVL_HIGH    = 2'b10,
    MVI_LVL_HIGHEST = 2'b11
  } mvi_level_e;

  localparam int unsigned MVI_NUM_SRC = 18;
  localparam int unsigned MVI_NUM_VEC = 10;
  localparam int unsigned MVI_MAX_SHARE = 3;
  localparam int unsigned MVI_VEC_W = 16;
  localparam int unsigned MVI_IDX_W = 4;

  // fixed vector addresses, lowest first
  localparam logic [15:0] MVI_VEC_ADDR [MVI_NUM_VEC] = '{
    16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023,
    16'h002b, 16'h0033, 16'h003b, 16'h0043, 16'h004b
  };
  // first source bit and number of sources merged on each vector
  localparam int unsigned MVI_VEC_FIRST [MVI_NUM_VEC] = '{0, 1, 2, 5, 7, 8, 10, 12, 14, 17};
  localparam int unsigned MVI_VEC_COUNT [MVI_NUM_VEC] = '{1, 1, 3, 2, 1, 2, 2, 2, 3, 1};
  // vectors that may use the highest level instead of high
  localparam logic [MVI_NUM_VEC-1:0] MVI_VEC_X_CAPABLE = 10'h003;

  // source bit positions
  localparam int unsigned MVI_SRC_EXT_IRQ_FIRST = 0;
  localparam int unsigned MVI_SRC_EXT_IRQ_SECOND = 1;
  localparam int unsigned MVI_SRC_EXT_IRQ_THIRD = 2;
  localparam int unsigned MVI_SRC_TIMER_ZERO_LOW = 3;
  localparam int unsigned MVI_SRC_EXT_IRQ_FIFTH = 4;
  localparam int unsigned MVI_SRC_EXT_IRQ_FOURTH = 5;
  localparam int unsigned MVI_SRC_BASE_TIMER = 6;
  localparam int unsigned MVI_SRC_TIMER_ZERO_HIGH = 7;
  localparam int unsigned MVI_SRC_TIMER_ONE_LOW = 8;
  localparam int unsigned MVI_SRC_TIMER_ONE_HIGH = 9;
  localparam int unsigned MVI_SRC_SYNC_SERIAL_UNIT = 10;
  localparam int unsigned MVI_SRC_ASYNC_PORT_RX = 11;
  localparam int unsigned MVI_SRC_SECOND_SERIAL_UNIT = 12;
  localparam int unsigned MVI_SRC_ASYNC_PORT_TX = 13;
  localparam int unsigned MVI_SRC_ADC_DONE = 14;
  localparam int unsigned MVI_SRC_TIMER_SIX = 15;
  localparam int unsigned MVI_SRC_TIMER_SEVEN = 16;
  localparam int unsigned MVI_SRC_PORT_ZERO = 17;

  // reset values
  localparam logic [2:0] MVI_SVC_RESET = 3'h0;
  localparam logic [15:0] MVI_VEC_RESET = 16'h0000;
  localparam logic [3:0] MVI_IDX_RESET = 4'h0;
endpackage : mvi_pkg
`default_nettype wire

// [shared/mvi_slot_if.sv]
`default_nettype none
interface mvi_slot_if;
  import mvi_pkg::*;
  logic pending;
  mvi_level_e level;
  modport slot (output pending, output level);
  modport arb (input pending, input level);
endinterface : mvi_slot_if
`default_nettype wire

// [src/mvi_vec_slot.sv]
`default_nettype none
module mvi_vec_slot
  import mvi_pkg::*;
#(
  parameter int unsigned NSRC = 1,
  parameter bit X_CAPABLE = 1'b0
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [NSRC-1:0] src_in,
  input wire logic enable_in,
  input wire logic level_sel_in,
  mvi_slot_if.slot slot_out
);
  if (NSRC < 1 || NSRC > MVI_MAX_SHARE) begin : g_bad_nsrc
    $error("mvi_vec_slot: NSRC must be 1 to 3");
  end

  // merged sources; software must look at source flags to find who asked
  wire logic any_src_w = |src_in;
  wire logic pend_w = any_src_w & enable_in;
  // level select: set picks the upper level this vector may use
  wire mvi_level_e upper_w = X_CAPABLE ? MVI_LVL_HIGHEST : MVI_LVL_HIGH;
  wire mvi_level_e sel_w = level_sel_in ? upper_w : MVI_LVL_LOW;

  assign slot_out.pending = pend_w;
  assign slot_out.level = pend_w ? sel_w : MVI_LVL_NONE;

  chk_disabled_silent : assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !enable_in |-> slot_out.level == MVI_LVL_NONE)
    else $error("disabled vector shows a level");
  chk_level_set_allowed : assert property (@(posedge clk_in) disable iff (!reset_n_in)
    slot_out.level != (X_CAPABLE ? MVI_LVL_HIGH : MVI_LVL_HIGHEST))
    else $error("vector shows a level it may not use");
  chk_low_select : assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (any_src_w && enable_in && !level_sel_in) |-> slot_out.level == MVI_LVL_LOW)
    else $error("low select not honoured");
endmodule : mvi_vec_slot
`default_nettype wire

// [bench/mvi_core_model.sv]
`default_nettype none
module mvi_core_model (
  input wire logic clk_in,
  input wire logic irq_req_in,
  input wire logic take_en_in,
  output var logic ack_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // take each offer once; low enable models a core busy mid-instruction
  initial ack_out = 1'b0;
  always @(posedge clk_in) begin
    ack_out <= #1 take_en_in && irq_req_in && !ack_out;
  end
endmodule : mvi_core_model
`default_nettype wire

// [bench/mvi_irq_ctrl_tb.sv]
`default_nettype none
module mvi_irq_ctrl_tb;
  import mvi_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_in, reset_n_in, ack_in, reti_in, take_en, irq_req_out;
  logic [MVI_NUM_SRC-1:0] src_in;
  logic [MVI_NUM_VEC-1:0] vec_enable_in, vec_level_sel_in;
  logic [MVI_VEC_W-1:0] vector_out;
  logic [MVI_IDX_W-1:0] vector_index_out;
  logic [1:0] req_level_out, service_level_out;
  int n_fail, checks_done;
  // vector number of each source bit, kept apart from the design tables
  int unsigned src_vec [MVI_NUM_SRC] = '{0, 1, 2, 2, 2, 3, 3, 4, 5, 5, 6, 6, 7, 7, 8, 8, 8, 9};

  mvi_irq_ctrl i_dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .src_in(src_in),
    .vec_enable_in(vec_enable_in), .vec_level_sel_in(vec_level_sel_in), .ack_in(ack_in),
    .reti_in(reti_in), .irq_req_out(irq_req_out), .vector_out(vector_out),
    .vector_index_out(vector_index_out), .req_level_out(req_level_out),
    .service_level_out(service_level_out));
  mvi_core_model i_core (.clk_in(clk_in), .irq_req_in(irq_req_out), .take_en_in(take_en),
    .ack_out(ack_in));

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // inputs move 1 ns after the edge, outputs are read once settled
  task automatic drive(input logic [17:0] src, input logic [9:0] en, input logic [9:0] lvl,
                       input int cyc);
    @(posedge clk_in);
    #1;
    src_in = src;
    vec_enable_in = en;
    vec_level_sel_in = lvl;
    repeat (cyc) @(posedge clk_in);
    #1;
  endtask : drive

  // bounded wait, since the core model decides when the ack lands
  task automatic wait_svc(input logic [1:0] exp);
    for (int i = 0; i < 10 && service_level_out !== exp; i++) @(posedge clk_in);
    #1;
    check(16'(service_level_out), 16'(exp));
  endtask : wait_svc

  task automatic pulse_reti();
    @(posedge clk_in);
    #1;
    reti_in = 1'b1;
    @(posedge clk_in);
    #1;
    reti_in = 1'b0;
  endtask : pulse_reti

  task automatic scan_sources();
    logic [15:0] exp_lvl;
    for (int s = 0; s < MVI_NUM_SRC; s++) begin
      for (int u = 0; u < 2; u++) begin
        drive(18'h00001 << s, 10'h3ff, {10{u[0]}}, 2);
        exp_lvl = (u == 0) ? 16'h1 : (src_vec[s] < 2) ? 16'h3 : 16'h2;
        check(16'(irq_req_out), 16'h1);
        check(vector_out, 16'h0003 + 16'(src_vec[s] * 8));
        check(16'(vector_index_out), 16'(src_vec[s]));
        check(16'(req_level_out), exp_lvl);
      end
    end
  endtask : scan_sources

  task automatic arbitration();
    drive('1, 10'h3ff, '0, 2);
    check(vector_out, 16'h0003);
    drive('1, 10'h3fe, '0, 2);
    check(vector_out, 16'h000b);
    drive(18'h20008, 10'h3ff, 10'h200, 2);
    check(vector_out, 16'h004b);
    drive(18'h20003, 10'h3ff, 10'h201, 2);
    check(vector_out, 16'h0003);
    drive('0, 10'h3ff, '0, 1);
  endtask : arbitration

  // low then high in service, unwound by two returns
  task automatic nesting();
    take_en = 1'b1;
    drive(18'h00100, 10'h3ff, '0, 1);
    wait_svc(2'h1);
    take_en = 1'b0;
    repeat (3) @(posedge clk_in);
    #1;
    check(16'(irq_req_out), 16'h0);
    drive(18'h00104, 10'h3ff, 10'h004, 2);
    check(16'(req_level_out), 16'h2);
    take_en = 1'b1;
    wait_svc(2'h2);
    take_en = 1'b0;
    drive(18'h00100, 10'h3ff, 10'h004, 1); // handler clears its own flag
    pulse_reti();
    wait_svc(2'h1);
    check(16'(irq_req_out), 16'h0);
    pulse_reti();
    wait_svc(2'h0);
    repeat (2) @(posedge clk_in);
    #1;
    check(vector_out, 16'h002b);
  endtask : nesting

  // low then highest in service; high held off, then let in by one return
  task automatic highest_nest();
    take_en = 1'b1;
    wait_svc(2'h1);
    take_en = 1'b0;
    drive(18'h00101, 10'h3ff, 10'h001, 2);
    check(16'(req_level_out), 16'h3);
    take_en = 1'b1;
    wait_svc(2'h3);
    take_en = 1'b0;
    drive(18'h00105, 10'h3ff, 10'h005, 2);
    check(16'(irq_req_out), 16'h0);
    drive(18'h00104, 10'h3ff, 10'h004, 1); // handler clears its own flag
    pulse_reti();
    wait_svc(2'h1);
    repeat (2) @(posedge clk_in);
    #1;
    check(vector_out, 16'h0013);
    check(16'(req_level_out), 16'h2);
  endtask : highest_nest

  task automatic give_verdict();
    $display("checks %0d, failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict

  initial begin
    n_fail = 0;
    checks_done = 0;
    reset_n_in = 1'b0;
    src_in = '0;
    vec_enable_in = '0;
    vec_level_sel_in = '0;
    reti_in = 1'b0;
    take_en = 1'b0;
    repeat (6) @(posedge clk_in);
    #1;
    check(16'(irq_req_out), 16'h0);
    check(vector_out, 16'h0000);
    reset_n_in = 1'b1;
    scan_sources();
    arbitration();
    nesting();
    highest_nest();
    give_verdict();
  end

  // the whole run needs well under 2000 cycles
  initial begin
    #200000;
    n_fail++;
    give_verdict();
  end
endmodule : mvi_irq_ctrl_tb
`default_nettype wire
